// >>> rtl/lid_params.svh
// constants of the line interface diagnostics block
// Behaviour
// - interrupt output gated by master enable bit
// - pending flag shows any interrupt request
// - pattern 2^23-1 at E3, else 2^15-1
// - pattern test only in host mode
// - checker enabled, lock drives violation pin low
// - out of lock: sync lost set, pin high
// - zero-to-one inject write adds one error
// - each error pulses pin high half cycle
// - error counter counts each detected error up to all ones, then holds
// - counter byte read copies other, clears both
// - loopback from pins or register bits
// - remote,local: normal, analog, remote, digital
// - analog loop: tx line feeds receiver
// - digital loop: tx inputs to rx outputs
// - remote loop: rx data retransmitted, rx clock
// - remote loop timed by recovered clock
// - remote loop ignores transmit inputs
// - all ones from pin or control bit
// - all ones sent as alternating marks
// - read-only device identifier register
// - read-only device revision register
`ifndef LID_PARAMS_SVH
`define LID_PARAMS_SVH
`define LID_A_CTRL     7'h04
`define LID_A_STAT     7'h05
`define LID_A_LOOP     7'h06
`define LID_A_IEN      7'h20
`define LID_A_IPEND    7'h21
`define LID_A_CNT_HI   7'h30
`define LID_A_CNT_LO   7'h31
`define LID_A_HOLD     7'h38
`define LID_A_ID       7'h3e
`define LID_A_REV      7'h3f
`define LID_B_ONES     0
`define LID_B_INJ      1
`define LID_B_E3       2
`define LID_B_LOC      3
`define LID_B_REM      4
`define LID_B_PAT      5
`define LID_FRAME_LAST 5'h0f
`define LID_HDR_LAST   5'h07
`define LID_LOCK_GOOD  6'h20
`define LID_LOSE_BAD   3'h4
`define LID_PRBS_SEED  23'h7fffff
`endif

// >>> rtl/lid_pkg.sv
// types of the line interface diagnostics block
package lid_pkg;
  typedef enum logic [1:0] {LP_NORMAL, LP_ANALOG, LP_REMOTE, LP_DIGITAL} lid_loop_e;
  typedef enum logic {SY_HUNT, SY_LOCK} lid_sync_e;
  typedef struct packed {
    logic pos;
    logic neg;
  } lid_rail_s;
endpackage

// >>> rtl/lid_prbs.sv
// pattern shift register, generator or self-synchronising checker
`timescale 1ns/100ps
`include "lid_params.svh"
module lid_prbs #(
  parameter bit CHECK = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control and data
  input  wire logic run,
  input  wire logic long_seq,
  input  wire logic din,
  output logic      bit_out
);
  logic [22:0] sr_q;
  logic        fb;

  // inverted sequences, no framing
  assign fb      = long_seq ? (sr_q[22] ^ sr_q[17]) : (sr_q[14] ^ sr_q[13]);
  assign bit_out = ~fb;

  // the checker loads received bits, so it relocks on its own after slips
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sr_q <= `LID_PRBS_SEED;
    end else if (run) begin
      sr_q <= {sr_q[21:0], CHECK ? ~din : fb};
    end
  end
endmodule

// >>> rtl/lid_top.sv
// diagnostics of a single channel line interface: pattern, loopbacks, registers
`timescale 1ns/100ps
`include "lid_params.svh"
module lid_top #(
  parameter int         CNT_W   = 16,
  parameter logic [7:0] DEV_ID  = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_REV = 8'h03  // arbitrary value
) (
  // system
  input  wire logic clk,
  input  wire logic reset,
  // mode straps and hardware-mode pins
  input  wire logic host_mode,
  input  wire logic remote_loop_select,
  input  wire logic local_loop_select,
  input  wire logic send_all_ones,
  // serial host port
  input  wire logic sp_cs_n,
  input  wire logic sp_sclk,
  input  wire logic sp_sdi,
  output logic      sp_sdo,
  output logic      sp_sdo_oe,
  // interrupt
  input  wire logic source_irq,
  output logic      int_n,
  // transmit side
  input  wire logic transmit_clock,
  input  wire logic tx_positive_data,
  input  wire logic tx_negative_data,
  output logic      line_tx_pair,
  output logic      line_tx_pair_return,
  // receive side
  input  wire logic cdr_clock,
  input  wire logic line_rx_pair,
  input  wire logic line_rx_pair_return,
  output logic      recovered_clock,
  output logic      rx_positive_data,
  output logic      rx_negative_or_violation_out
);
  // ---------------------------------------------------------------
  // pin synchronisers and serial framing
  // ---------------------------------------------------------------
  logic [6:0] pin_m_q, pin_s_q;
  logic       sclk_prev_q, sclk_rise;
  logic [4:0] bit_q;
  logic [6:0] sh_q;
  logic [6:0] addr_q;
  logic       rw_q;
  logic [7:0] out_q, rdata, wdata;
  logic       rd_hit, rd_stb_q, rd_stb, wr_stb;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_m_q <= 7'h00;
      pin_s_q <= 7'h00;
    end else begin
      pin_m_q <= {host_mode, remote_loop_select, local_loop_select, send_all_ones,
                  sp_cs_n, sp_sclk, sp_sdi};
      pin_s_q <= pin_m_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_s_q[1];
    end
  end
  assign sclk_rise = pin_s_q[1] & ~sclk_prev_q & ~pin_s_q[2];

  // frame: read flag, seven address bits, eight data bits, msb first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_q  <= 5'h00;
      sh_q   <= 7'h00;
      addr_q <= 7'h00;
      rw_q   <= 1'b0;
    end else if (pin_s_q[2]) begin
      bit_q <= 5'h00;
      rw_q  <= 1'b0;
    end else if (sclk_rise) begin
      sh_q <= {sh_q[5:0], pin_s_q[0]};
      if (bit_q != `LID_FRAME_LAST) begin
        bit_q <= bit_q + 5'h01;
      end
      if (bit_q == `LID_HDR_LAST) begin
        rw_q   <= sh_q[6];
        addr_q <= {sh_q[5:0], pin_s_q[0]};
      end
    end
  end
  assign rd_hit = sclk_rise && bit_q == `LID_HDR_LAST && sh_q[6];
  assign wr_stb = sclk_rise && bit_q == `LID_FRAME_LAST && !rw_q;
  assign wdata  = {sh_q, pin_s_q[0]};

  // the read waits one cycle, until addr_q holds the address just shifted in
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_stb_q <= 1'b0;
    end else begin
      rd_stb_q <= rd_hit;
    end
  end
  assign rd_stb = rd_stb_q;

  // device drives after rising edges; host samples on falling edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= 8'h00;
    end else if (rd_stb) begin
      out_q <= rdata;
    end else if (sclk_rise && rw_q) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end
  assign sp_sdo    = out_q[7];
  assign sp_sdo_oe = !pin_s_q[2] && rw_q;

  // ---------------------------------------------------------------
  // control registers and mode selection
  // ---------------------------------------------------------------
  logic              ien_q, ones_bit_q, inj_bit_q, e3_q, loc_bit_q, rem_bit_q, pat_bit_q;
  logic              inj_tgl_q, host, rem_eff, loc_eff, ones_eff, pat_eff, sync_lost;
  lid_pkg::lid_loop_e loop;
  logic [CNT_W-1:0]  cnt_q;
  logic [7:0]        hold_q;
  logic              err_evt;
  logic              cnt_rd;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ien_q      <= 1'b0;
      ones_bit_q <= 1'b0;
      inj_bit_q  <= 1'b0;
      e3_q       <= 1'b0;
      loc_bit_q  <= 1'b0;
      rem_bit_q  <= 1'b0;
      pat_bit_q  <= 1'b0;
    end else if (wr_stb) begin
      case (addr_q)
        `LID_A_IEN: ien_q <= wdata[0];
        `LID_A_CTRL: begin
          ones_bit_q <= wdata[`LID_B_ONES];
          inj_bit_q  <= wdata[`LID_B_INJ];
          e3_q       <= wdata[`LID_B_E3];
        end
        `LID_A_LOOP: begin
          loc_bit_q <= wdata[`LID_B_LOC];
          rem_bit_q <= wdata[`LID_B_REM];
          pat_bit_q <= wdata[`LID_B_PAT];
        end
        default: ;
      endcase
    end
  end

  // one error per zero-to-one write; a repeated one does nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inj_tgl_q <= 1'b0;
    end else if (wr_stb && addr_q == `LID_A_CTRL && wdata[`LID_B_INJ] && !inj_bit_q
                 && pat_eff) begin
      inj_tgl_q <= ~inj_tgl_q;
    end
  end

  assign host     = pin_s_q[6];
  assign rem_eff  = host ? rem_bit_q : pin_s_q[5];
  assign loc_eff  = host ? loc_bit_q : pin_s_q[4];
  assign ones_eff = host ? ones_bit_q : pin_s_q[3];
  assign pat_eff  = host && pat_bit_q;

  always_comb begin
    case ({rem_eff, loc_eff})
      2'b01:   loop = lid_pkg::LP_ANALOG;
      2'b10:   loop = lid_pkg::LP_REMOTE;
      2'b11:   loop = lid_pkg::LP_DIGITAL;
      default: loop = lid_pkg::LP_NORMAL;
    endcase
  end

  always_comb begin
    case (addr_q)
      `LID_A_IEN:    rdata = {7'h00, ien_q};
      `LID_A_IPEND:  rdata = {7'h00, source_irq};
      `LID_A_CTRL:   rdata = {5'h00, e3_q, inj_bit_q, ones_bit_q};
      `LID_A_STAT:   rdata = {7'h00, sync_lost};
      `LID_A_LOOP:   rdata = {2'h0, pat_bit_q, rem_bit_q, loc_bit_q, 3'h0};
      `LID_A_CNT_HI: rdata = cnt_q[15:8];
      `LID_A_CNT_LO: rdata = cnt_q[7:0];
      `LID_A_HOLD:   rdata = hold_q;
      `LID_A_ID:     rdata = DEV_ID;
      `LID_A_REV:    rdata = DEV_REV;
      default:       rdata = 8'h00;
    endcase
  end

  assign int_n  = ~(ien_q & source_irq);
  assign cnt_rd = rd_stb && (addr_q[6:0] == `LID_A_CNT_HI || addr_q[6:0] == `LID_A_CNT_LO);

  // a read clears the counter, but an error in that same cycle still counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      hold_q <= 8'h00;
    end else begin
      if (cnt_rd) begin
        hold_q <= (addr_q == `LID_A_CNT_HI) ? cnt_q[7:0] : cnt_q[15:8];
        cnt_q  <= {{(CNT_W-1){1'b0}}, err_evt && pat_eff};
      end else if (err_evt && pat_eff && !(&cnt_q)) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit domain (recovered clock during remote loop)
  // ---------------------------------------------------------------
  logic               tx_clk;
  logic [5:0]         txc_m_q, txc_s_q;
  logic               tx_inj_q, tx_inj_flip, tx_gen_bit, ami_q;
  lid_pkg::lid_rail_s tx_line_q, rx_line_q;

  assign tx_clk = (loop == lid_pkg::LP_REMOTE) ? cdr_clock : transmit_clock;

  // every mode bit, the digital loop included, crosses through the same two stages
  always_ff @(posedge tx_clk or posedge reset) begin
    if (reset) begin
      txc_m_q  <= 6'h00;
      txc_s_q  <= 6'h00;
      tx_inj_q <= 1'b0;
    end else begin
      txc_m_q  <= {loop == lid_pkg::LP_DIGITAL, inj_tgl_q, pat_eff, e3_q, ones_eff,
                   loop == lid_pkg::LP_REMOTE};
      txc_s_q  <= txc_m_q;
      tx_inj_q <= txc_s_q[4];
    end
  end
  assign tx_inj_flip = txc_s_q[4] ^ tx_inj_q;

  lid_prbs #(.CHECK(1'b0)) u_gen (
    .clk      (tx_clk),
    .reset    (reset),
    .run      (txc_s_q[3]),
    .long_seq (txc_s_q[2]),
    .din      (1'b0),
    .bit_out  (tx_gen_bit)
  );

  // remote loop wins, then digital loop keeps the line quiet, then all ones, then pattern
  always_ff @(posedge tx_clk or posedge reset) begin
    if (reset) begin
      tx_line_q <= '0;
      ami_q     <= 1'b0;
    end else if (txc_s_q[0]) begin
      tx_line_q <= rx_line_q;
    end else if (txc_s_q[5]) begin
      tx_line_q <= '0;
    end else if (txc_s_q[1]) begin
      ami_q     <= ~ami_q;
      tx_line_q <= {~ami_q, ami_q};
    end else if (txc_s_q[3]) begin
      if (tx_gen_bit ^ tx_inj_flip) begin
        ami_q     <= ~ami_q;
        tx_line_q <= {~ami_q, ami_q};
      end else begin
        tx_line_q <= '0;
      end
    end else begin
      tx_line_q <= {tx_positive_data, tx_negative_data};
    end
  end
  assign line_tx_pair        = tx_line_q.pos;
  assign line_tx_pair_return = tx_line_q.neg;

  // ---------------------------------------------------------------
  // receive domain and pattern checker
  // ---------------------------------------------------------------
  logic               rx_clk, rx_bit, rx_pred, rx_err_q, rx_err_tgl_q;
  logic [3:0]         rxc_m_q, rxc_s_q;
  lid_pkg::lid_sync_e sync_q;
  logic [5:0]         good_q;
  logic [2:0]         bad_q;
  logic [2:0]         err_sy_q, lost_sy_q;

  // internal loops take the transmit clock; glitches only at mode changes
  assign rx_clk = (loop == lid_pkg::LP_ANALOG || loop == lid_pkg::LP_DIGITAL)
                  ? transmit_clock : cdr_clock;

  always_ff @(posedge rx_clk or posedge reset) begin
    if (reset) begin
      rxc_m_q <= 4'h0;
      rxc_s_q <= 4'h0;
    end else begin
      rxc_m_q <= {pat_eff, e3_q, loop == lid_pkg::LP_ANALOG, loop == lid_pkg::LP_DIGITAL};
      rxc_s_q <= rxc_m_q;
    end
  end

  always_ff @(posedge rx_clk or posedge reset) begin
    if (reset) begin
      rx_line_q <= '0;
    end else if (rxc_s_q[1]) begin
      rx_line_q <= tx_line_q;
    end else if (rxc_s_q[0]) begin
      rx_line_q <= {tx_positive_data, tx_negative_data};
    end else begin
      rx_line_q <= {line_rx_pair, line_rx_pair_return};
    end
  end
  assign rx_bit = rx_line_q.pos | rx_line_q.neg;

  lid_prbs #(.CHECK(1'b1)) u_chk (
    .clk      (rx_clk),
    .reset    (reset),
    .run      (rxc_s_q[3]),
    .long_seq (rxc_s_q[2]),
    .din      (rx_bit),
    .bit_out  (rx_pred)
  );

  // lock after a run of good bits; drop after several errors between good runs
  always_ff @(posedge rx_clk or posedge reset) begin
    if (reset) begin
      sync_q <= lid_pkg::SY_HUNT;
      good_q <= 6'h00;
      bad_q  <= 3'h0;
    end else if (!rxc_s_q[3]) begin
      sync_q <= lid_pkg::SY_HUNT;
      good_q <= 6'h00;
      bad_q  <= 3'h0;
    end else begin
      case (sync_q)
        lid_pkg::SY_HUNT: begin
          good_q <= (rx_pred != rx_bit) ? 6'h00 : good_q + 6'h01;
          if (rx_pred == rx_bit && good_q == `LID_LOCK_GOOD - 6'h01) begin
            sync_q <= lid_pkg::SY_LOCK;
            bad_q  <= 3'h0;
          end
        end
        lid_pkg::SY_LOCK: begin
          if (rx_pred != rx_bit) begin
            bad_q  <= bad_q + 3'h1;
            good_q <= 6'h00;
            if (bad_q == `LID_LOSE_BAD - 3'h1) begin
              sync_q <= lid_pkg::SY_HUNT;
            end
          end else if (good_q == `LID_LOCK_GOOD - 6'h01) begin
            bad_q <= 3'h0;
          end else begin
            good_q <= good_q + 6'h01;
          end
        end
        default: sync_q <= lid_pkg::SY_HUNT;
      endcase
    end
  end

  always_ff @(posedge rx_clk or posedge reset) begin
    if (reset) begin
      rx_err_q     <= 1'b0;
      rx_err_tgl_q <= 1'b0;
    end else begin
      rx_err_q <= rxc_s_q[3] && rx_pred != rx_bit;
      if (rxc_s_q[3] && rx_pred != rx_bit) begin
        rx_err_tgl_q <= ~rx_err_tgl_q;
      end
    end
  end

  // error pulse covers the high half of the receive clock
  assign rx_negative_or_violation_out = rxc_s_q[3]
    ? (sync_q != lid_pkg::SY_LOCK || (rx_err_q && rx_clk))
    : rx_line_q.neg;
  assign rx_positive_data = rx_line_q.pos;
  assign recovered_clock  = rx_clk;

  // error toggle and lock state into the register clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_sy_q  <= 3'h0;
      lost_sy_q <= 3'h0;
    end else begin
      err_sy_q  <= {err_sy_q[1:0], rx_err_tgl_q};
      lost_sy_q <= {lost_sy_q[1:0], sync_q != lid_pkg::SY_LOCK && rxc_s_q[3]};
    end
  end
  assign err_evt   = err_sy_q[2] ^ err_sy_q[1];
  assign sync_lost = lost_sy_q[1];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_int_gate;
    @(posedge clk) disable iff (reset) !int_n |-> ien_q && source_irq;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt without enable");

  property p_pend_read;
    @(posedge clk) disable iff (reset)
      rd_stb && addr_q == `LID_A_IPEND |=> out_q[7:1] == 7'h00 && out_q[0] == $past(source_irq);
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending flag read wrong");

  property p_hw_no_pattern;
    @(posedge clk) disable iff (reset) !host |-> !pat_eff;
  endproperty
  a_hw_no_pattern: assert property (p_hw_no_pattern) else $error("pattern in hw mode");

  property p_inject_once;
    @(posedge clk) disable iff (reset)
      wr_stb && addr_q == `LID_A_CTRL && inj_bit_q |=> $stable(inj_tgl_q);
  endproperty
  a_inject_once: assert property (p_inject_once) else $error("repeat one injected");

  property p_count_up;
    @(posedge clk) disable iff (reset)
      err_evt && pat_eff && !cnt_rd && cnt_q != 16'hffff |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("error not counted");

  property p_read_clear;
    @(posedge clk) disable iff (reset)
      cnt_rd && addr_q == `LID_A_CNT_HI |=> cnt_q <= 16'h0001 && hold_q == $past(cnt_q[7:0]);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("counter read effect wrong");

  property p_digital_quiet;
    @(posedge tx_clk) disable iff (reset)
      txc_s_q[5] && !txc_s_q[0] |=> tx_line_q == '0;
  endproperty
  a_digital_quiet: assert property (p_digital_quiet) else $error("line driven in loop");

  property p_all_ones;
    @(posedge tx_clk) disable iff (reset)
      txc_s_q[1] && !txc_s_q[0] && !txc_s_q[5]
      |=> tx_line_q.pos != tx_line_q.neg && tx_line_q.pos == !$past(ami_q);
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("all ones not alternating");

  property p_unlock_high;
    @(posedge rx_clk) disable iff (reset)
      rxc_s_q[3] && sync_q == lid_pkg::SY_HUNT |-> rx_negative_or_violation_out;
  endproperty
  a_unlock_high: assert property (p_unlock_high) else $error("pin low while unlocked");
endmodule

// >>> sim/lid_far_end.sv
// far end model: framer data and clocks, line clock recovery, optional cable return
`timescale 1ns/100ps
module lid_far_end (
  // control from the bench
  input  wire logic               line_loop,
  input  wire lid_pkg::lid_rail_s tx_word,
  input  wire lid_pkg::lid_rail_s rx_word,
  // line output of the device
  input  wire logic               line_tx_pair,
  input  wire logic               line_tx_pair_return,
  // towards the device
  output logic                    transmit_clock,
  output logic                    cdr_clock,
  output logic                    tx_positive_data,
  output logic                    tx_negative_data,
  output logic                    line_rx_pair,
  output logic                    line_rx_pair_return
);
  // ------------------------------------------------------------
  // line clocks
  // ------------------------------------------------------------
  // line traffic is continuous, so both clocks run free; the odd offset
  // keeps the recovered clock out of phase with the framer clock
  initial begin
    transmit_clock = 1'b0;
    cdr_clock = 1'b0;
    tx_positive_data = 1'b0;
    tx_negative_data = 1'b0;
    line_rx_pair = 1'b0;
    line_rx_pair_return = 1'b0;
    #37;
    forever #80 cdr_clock = ~cdr_clock;
  end
  always #80 transmit_clock = ~transmit_clock;
  // ------------------------------------------------------------
  // data launch
  // ------------------------------------------------------------
  // launched on falling edges so the device samples settled rails
  always @(negedge transmit_clock) begin
    tx_positive_data <= tx_word.pos;
    tx_negative_data <= tx_word.neg;
  end
  // a looped cable returns what the device sent, timed by the line clock
  always @(negedge cdr_clock) begin
    line_rx_pair        <= line_loop ? line_tx_pair : rx_word.pos;
    line_rx_pair_return <= line_loop ? line_tx_pair_return : rx_word.neg;
  end
endmodule

// >>> sim/tb_lid_top.sv
// self-checking bench of the line interface diagnostics block
`timescale 1ns/100ps
`include "lid_params.svh"
module tb_lid_top;
  localparam logic [7:0] ID_V  = 8'h6c; // arbitrary value
  localparam logic [7:0] REV_V = 8'h02; // arbitrary value
  localparam int         LIMIT = 40000;
  logic               clk, reset, host_mode, remote_loop_select, local_loop_select;
  logic               send_all_ones, sp_cs_n, sp_sclk, sp_sdi, sp_sdo, sp_sdo_oe;
  logic               source_irq, int_n, transmit_clock, tx_positive_data, tx_negative_data;
  logic               line_tx_pair, line_tx_pair_return, cdr_clock, line_rx_pair;
  logic               line_rx_pair_return, recovered_clock, rx_positive_data;
  logic               rx_negative_or_violation_out, line_loop, pulse_en;
  lid_pkg::lid_rail_s tx_word, rx_word;
  int                 err_total, total_checks, cyc, pulse_hi, pulse_lo;

  lid_top #(.DEV_ID(ID_V), .DEV_REV(REV_V)) lid_top_inst (
    .clk, .reset, .host_mode, .remote_loop_select, .local_loop_select, .send_all_ones,
    .sp_cs_n, .sp_sclk, .sp_sdi, .sp_sdo, .sp_sdo_oe, .source_irq, .int_n,
    .transmit_clock, .tx_positive_data, .tx_negative_data, .line_tx_pair,
    .line_tx_pair_return, .cdr_clock, .line_rx_pair, .line_rx_pair_return,
    .recovered_clock, .rx_positive_data, .rx_negative_or_violation_out
  );
  lid_far_end lid_far_end_inst (
    .line_loop, .tx_word, .rx_word, .line_tx_pair, .line_tx_pair_return, .transmit_clock,
    .cdr_clock, .tx_positive_data, .tx_negative_data, .line_rx_pair, .line_rx_pair_return
  );
  // ------------------------------------------------------------
  // clock, timeout and pulse watch
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end
  // sampled mid-high and mid-low, so a pulse wider than half a cycle shows up
  always @(posedge recovered_clock) begin
    #40;
    if (pulse_en && rx_negative_or_violation_out === 1'b1) pulse_hi++;
    #80;
    if (pulse_en && rx_negative_or_violation_out === 1'b1) pulse_lo++;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each sclk phase lasts 6 clk, above the 4 the port synchronisers need
  task automatic sp_frame(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                          output logic [7:0] q);
    logic [15:0] sh;
    sh = {rd, a, wd};
    q = 8'h00;
    sp_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sp_sdi <= sh[i];
      repeat (6) @(posedge clk);
      sp_sclk <= 1'b1;
      repeat (6) @(posedge clk);
      if (rd && i >= 1 && i <= 8) q = {q[6:0], sp_sdo};
      if (rd && i == 8) check({7'h00, sp_sdo_oe}, 8'h01);
      sp_sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    sp_cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    sp_frame(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    sp_frame(1'b1, a, 8'h00, q);
    check(q, exp);
  endtask
  task automatic tx_wait(input int n);
    repeat (n) @(posedge transmit_clock);
    @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`LID_A_IEN, 8'h00);
    wr(`LID_A_ID, 8'h00);
    wr(`LID_A_REV, 8'hff);
    rd_chk(`LID_A_ID, ID_V);
    rd_chk(`LID_A_REV, REV_V);
    rd_chk(7'h22, 8'h00);
  endtask
  task automatic t_irq();
    source_irq <= 1'b1;
    rd_chk(`LID_A_IPEND, 8'h01);
    check({7'h00, int_n}, 8'h01);
    wr(`LID_A_IEN, 8'h01);
    rd_chk(`LID_A_IEN, 8'h01);
    check({7'h00, int_n}, 8'h00);
    source_irq <= 1'b0;
    rd_chk(`LID_A_IPEND, 8'h00);
    check({7'h00, int_n}, 8'h01);
    wr(`LID_A_IEN, 8'h00);
    source_irq <= 1'b1;
    rd_chk(`LID_A_IPEND, 8'h01);
    check({7'h00, int_n}, 8'h01);
    source_irq <= 1'b0;
  endtask
  // host pass ends in digital loop, so the pin pass also proves the bits are ignored
  task automatic t_loops();
    logic [2:0] exp [4];
    logic [2:0] seen;
    exp = '{3'b101, 3'b110, 3'b001, 3'b010};
    for (int hw = 0; hw < 2; hw++) begin
      for (int m = 0; m < 4; m++) begin
        host_mode <= (hw == 0);
        remote_loop_select <= (hw == 1) && m[1];
        local_loop_select <= (hw == 1) && m[0];
        if (hw == 0) wr(`LID_A_LOOP, {3'h0, m[1:0], 3'h0});
        repeat (12) @(posedge transmit_clock);
        #20;
        seen = {line_tx_pair, rx_positive_data, rx_negative_or_violation_out};
        check({5'h00, seen}, {5'h00, exp[m]});
        check({7'h00, recovered_clock}, {7'h00, m[0] ? transmit_clock : cdr_clock});
        @(posedge clk);
      end
    end
    host_mode <= 1'b1;
    remote_loop_select <= 1'b0;
    local_loop_select <= 1'b0;
    wr(`LID_A_LOOP, 8'h00);
  endtask
  task automatic t_ones();
    logic prev;
    prev = 1'b0;
    for (int hw = 1; hw >= 0; hw--) begin
      host_mode <= (hw == 0);
      send_all_ones <= (hw == 1);
      if (hw == 0) wr(`LID_A_CTRL, 8'h01);
      repeat (8) @(posedge transmit_clock);
      for (int i = 0; i < 8; i++) begin
        @(posedge transmit_clock);
        #20;
        check({7'h00, line_tx_pair ^ line_tx_pair_return}, 8'h01);
        if (i > 0) check({7'h00, line_tx_pair}, {7'h00, ~prev});
        prev = line_tx_pair;
      end
      @(posedge clk);
    end
    wr(`LID_A_CTRL, 8'h00);
  endtask
  // the far end cable loops the line, so the checker sees its own generator
  task automatic t_pattern();
    int n;
    logic [7:0] q;
    line_loop <= 1'b1;
    for (int e3 = 0; e3 < 2; e3++) begin
      wr(`LID_A_CTRL, {5'h00, e3[0], 2'b00});
      wr(`LID_A_LOOP, 8'h20);
      rd_chk(`LID_A_STAT, 8'h01);
      check({7'h00, rx_negative_or_violation_out}, 8'h01);
      tx_wait(80);
      rd_chk(`LID_A_STAT, 8'h00);
      check({7'h00, rx_negative_or_violation_out}, 8'h00);
      sp_frame(1'b1, `LID_A_CNT_HI, 8'h00, q);
      rd_chk(`LID_A_CNT_LO, 8'h00);
      pulse_hi = 0;
      pulse_lo = 0;
      pulse_en = 1'b1;
      wr(`LID_A_CTRL, {5'h00, e3[0], 2'b10});
      tx_wait(48);
      n = pulse_hi;
      check({7'h00, n != 0}, 8'h01);
      rd_chk(`LID_A_CNT_LO, n[7:0]);
      rd_chk(`LID_A_HOLD, 8'h00);
      rd_chk(`LID_A_CNT_HI, 8'h00);
      wr(`LID_A_CTRL, {5'h00, e3[0], 2'b10});
      tx_wait(48);
      check(pulse_hi[7:0], n[7:0]);
      wr(`LID_A_CTRL, {5'h00, e3[0], 2'b00});
      wr(`LID_A_CTRL, {5'h00, e3[0], 2'b10});
      tx_wait(48);
      pulse_en = 1'b0;
      check(pulse_hi[7:0], {n[6:0], 1'b0});
      check(pulse_lo[7:0], 8'h00);
      rd_chk(`LID_A_CNT_HI, 8'h00);
      rd_chk(`LID_A_HOLD, n[7:0]);
      wr(`LID_A_LOOP, 8'h00);
    end
    wr(`LID_A_CTRL, 8'h00);
    line_loop <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  // reset acts asynchronously, so no link clock edge is needed inside it
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    host_mode = 1'b1;
    remote_loop_select = 1'b0;
    local_loop_select = 1'b0;
    send_all_ones = 1'b0;
    sp_cs_n = 1'b1;
    sp_sclk = 1'b0;
    sp_sdi = 1'b0;
    source_irq = 1'b0;
    line_loop = 1'b0;
    pulse_en = 1'b0;
    tx_word = '{pos: 1'b1, neg: 1'b0};
    rx_word = '{pos: 1'b0, neg: 1'b1};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (40) @(posedge clk);
    t_regs();
    t_irq();
    t_loops();
    t_ones();
    t_pattern();
    report_and_stop();
  end
endmodule
